// ===== src/pmc_pkg.sv
package pmc_pkg;

  // ----------------------------------------------------------------
  // mode control fields, bits 14 down to 6 of the register
  // ----------------------------------------------------------------
  typedef struct packed {
    logic loopback;
    logic speedLsb;
    logic anegEnable;
    logic powerDown;
    logic isolate;
    logic anegRestart;
    logic fullDuplex;
    logic collisionTest;
    logic speedMsb;
  } pmc_mode_type;

  // ----------------------------------------------------------------
  // register map and field layout
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_MODE = 5'h00;
  localparam logic [4:0] REG_PAGE = 5'h1f;
  localparam logic [4:0] REG_MAIN_LO = 5'h10;
  localparam int BIT_SWRESET = 15;
  localparam int MODE_HI = 14;
  localparam int MODE_LO = 6;
  localparam logic [5:0] MODE_RSVD = 6'h00;
  localparam pmc_mode_type MODE_RESET = 9'h0c0;
  localparam logic [8:0] RESTART_MASK = 9'h008;
  localparam logic [15:0] PAGE_MAIN = 16'h0000;

  // ----------------------------------------------------------------
  // management frame
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [3:0] HDR_LAST = 4'hb;
  localparam logic [3:0] DATA_LAST = 4'hf;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int SW_RESET_NS = 1000;
  localparam int SW_RESET_CYC = (SW_RESET_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_START = 5'b00010,
    ST_HDR = 5'b00100,
    ST_TURN = 5'b01000,
    ST_DATA = 5'b10000
  } pmc_state_type;

endpackage : pmc_pkg

// ===== src/pmc_sync2.sv
`timescale 1ns/1ns
module pmc_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // pins in, synchronised levels out
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_widthCheck
    $error("pmc_sync2: WIDTH must be at least 1");
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule : pmc_sync2

// ===== src/pmc_mode_control.sv
`timescale 1ns/1ns
// How it works
// - registers 16 to 30 reachable only while page select register holds zero
// - writing one to bit 15 restores defaults, then the bit clears itself
// - bit 14 loops data back at the currently selected speed and duplex
// - speed code is bit 6 then bit 13; 00 is 10 Mbps, 01 100 Mbps
// - writing one to bit 9 restarts autonegotiation; bit clears itself
// - bit 11 puts the device into power-down
// - bit 10 isolates the MAC side, outputs undriven and inputs ignored
// - bit 8 selects full duplex when one, half duplex when zero
// - bit 7 enables the collision test
module pmc_mode_control #(
  parameter logic [4:0] PHY_ADDR = 5'h00,
  parameter int PRE_LEN = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // management interface pins
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  // mode controls toward the datapath
  output pmc_pkg::pmc_mode_type modeCtrl,
  output logic swResetBusy,
  output logic mainPageSel
);

  // refused at elaboration: the preamble counter is six bits wide
  if (PRE_LEN < 1 || PRE_LEN > 63) begin : g_preLenCheck
    $error("pmc_mode_control: PRE_LEN out of range");
  end

  localparam int RST_WAIT = pmc_pkg::SW_RESET_CYC;
  localparam logic [5:0] PRE_NEED = 6'(PRE_LEN);
  localparam logic [8:0] RST_LAST = 9'(pmc_pkg::SW_RESET_CYC - 1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic reachable(input logic [4:0] addr, input logic [15:0] page);
    reachable = (addr < pmc_pkg::REG_MAIN_LO) || (addr == pmc_pkg::REG_PAGE) ||
                (page == pmc_pkg::PAGE_MAIN);
  endfunction : reachable

  function automatic logic [15:0] readValue(input logic [4:0] addr,
                                            input pmc_pkg::pmc_mode_type mode,
                                            input logic busy, input logic [15:0] page);
    readValue = 16'h0000;
    if (!reachable(addr, page)) readValue = 16'h0000;
    else if (addr == pmc_pkg::REG_MODE) readValue = {busy, mode, pmc_pkg::MODE_RSVD};
    else if (addr == pmc_pkg::REG_PAGE) readValue = page;
  endfunction : readValue

  // ----------------------------------------------------------------
  // pin synchronisers and clock edge
  // ----------------------------------------------------------------
  logic [1:0] pinSync;
  logic mdcPrev_q;
  logic mdcRise;
  logic mdioBit;

  pmc_sync2 #(.WIDTH(2)) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .din({mdc, mdioIn}),
    .dout(pinSync)
  );

  assign mdcRise = pinSync[1] & ~mdcPrev_q;
  assign mdioBit = pinSync[0];

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mdcPrev_q <= 1'b0;
    end else begin
      mdcPrev_q <= pinSync[1];
    end
  end

  // ----------------------------------------------------------------
  // management frame engine
  // ----------------------------------------------------------------
  pmc_pkg::pmc_state_type state_q;
  logic [5:0] preCnt_q;
  logic [3:0] bitCnt_q;
  logic [15:0] shift_q;
  logic [15:0] rdShift_q;
  logic isRead_q;
  logic hit_q;
  logic [4:0] regAddr_q;
  logic wrStb_q;
  logic [15:0] wrData_q;
  logic [11:0] header;

  pmc_pkg::pmc_mode_type mode_q;
  logic busy_q;
  logic [8:0] rstCnt_q;
  logic [15:0] page_q;
  logic mainPage_q;

  assign header = {shift_q[10:0], mdioBit};

  // no preamble suppression: every frame needs the full run of ones
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= pmc_pkg::ST_IDLE;
      preCnt_q <= 6'h00;
      bitCnt_q <= 4'h0;
      shift_q <= 16'h0000;
      rdShift_q <= 16'h0000;
      isRead_q <= 1'b0;
      hit_q <= 1'b0;
      regAddr_q <= 5'h00;
      wrStb_q <= 1'b0;
      wrData_q <= 16'h0000;
      mdioOut <= 1'b0;
      mdioOe <= 1'b0;
    end else begin
      wrStb_q <= 1'b0;
      if (mdcRise) begin
        case (state_q)
          pmc_pkg::ST_IDLE: begin
            if (mdioBit) begin
              if (preCnt_q < PRE_NEED) preCnt_q <= preCnt_q + 6'h01;
            end else begin
              if (preCnt_q >= PRE_NEED) state_q <= pmc_pkg::ST_START;
              preCnt_q <= 6'h00;
            end
          end
          pmc_pkg::ST_START: begin
            bitCnt_q <= 4'h0;
            state_q <= mdioBit ? pmc_pkg::ST_HDR : pmc_pkg::ST_IDLE;
          end
          pmc_pkg::ST_HDR: begin
            shift_q <= {shift_q[14:0], mdioBit};
            bitCnt_q <= bitCnt_q + 4'h1;
            if (bitCnt_q == pmc_pkg::HDR_LAST) begin
              state_q <= pmc_pkg::ST_TURN;
              bitCnt_q <= 4'h0;
              isRead_q <= header[11:10] == pmc_pkg::OP_READ;
              hit_q <= (header[9:5] == PHY_ADDR) &&
                       (header[11:10] == pmc_pkg::OP_READ || header[11:10] == pmc_pkg::OP_WRITE);
              regAddr_q <= header[4:0];
              rdShift_q <= readValue(header[4:0], mode_q, busy_q, page_q);
            end
          end
          pmc_pkg::ST_TURN: begin
            bitCnt_q <= bitCnt_q + 4'h1;
            if (bitCnt_q == 4'h0) begin
              mdioOe <= hit_q & isRead_q;
              mdioOut <= 1'b0;
            end else begin
              state_q <= pmc_pkg::ST_DATA;
              bitCnt_q <= 4'h0;
              mdioOut <= rdShift_q[15];
              rdShift_q <= {rdShift_q[14:0], 1'b0};
            end
          end
          pmc_pkg::ST_DATA: begin
            bitCnt_q <= bitCnt_q + 4'h1;
            shift_q <= {shift_q[14:0], mdioBit};
            mdioOut <= rdShift_q[15];
            rdShift_q <= {rdShift_q[14:0], 1'b0};
            if (bitCnt_q == pmc_pkg::DATA_LAST) begin
              state_q <= pmc_pkg::ST_IDLE;
              mdioOe <= 1'b0;
              mdioOut <= 1'b0;
              wrStb_q <= hit_q & ~isRead_q & reachable(regAddr_q, page_q);
              wrData_q <= {shift_q[14:0], mdioBit};
            end
          end
          default: begin
            state_q <= pmc_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // mode control and page select registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= pmc_pkg::MODE_RESET;
      busy_q <= 1'b0;
      rstCnt_q <= 9'h000;
      page_q <= pmc_pkg::PAGE_MAIN;
      mainPage_q <= 1'b1;
    end else begin
      mode_q.anegRestart <= 1'b0;
      if (busy_q) begin
        // writes during the reset window are dropped; reads still see bit 15 set
        rstCnt_q <= rstCnt_q + 9'h001;
        if (rstCnt_q == RST_LAST) begin
          busy_q <= 1'b0;
          rstCnt_q <= 9'h000;
          mode_q <= pmc_pkg::MODE_RESET;
          page_q <= pmc_pkg::PAGE_MAIN;
          mainPage_q <= 1'b1;
        end
      end else if (wrStb_q && regAddr_q == pmc_pkg::REG_MODE) begin
        if (wrData_q[pmc_pkg::BIT_SWRESET]) begin
          busy_q <= 1'b1;
          rstCnt_q <= 9'h000;
        end else begin
          mode_q <= wrData_q[pmc_pkg::MODE_HI:pmc_pkg::MODE_LO];
        end
      end else if (wrStb_q && regAddr_q == pmc_pkg::REG_PAGE) begin
        page_q <= wrData_q;
        mainPage_q <= wrData_q == pmc_pkg::PAGE_MAIN;
      end
    end
  end

  assign modeCtrl = mode_q;
  assign swResetBusy = busy_q;
  assign mainPageSel = mainPage_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  swResetHold_a: assert property ($rose(busy_q) |-> busy_q [*8])
    else $error("software reset released too early");
  swResetDone_a: assert property ($rose(busy_q) |-> ##RST_WAIT
      (!busy_q && mode_q == pmc_pkg::MODE_RESET && page_q == pmc_pkg::PAGE_MAIN))
    else $error("software reset did not restore defaults on time");
  restartPulse_a: assert property (wrStb_q && !busy_q && regAddr_q == pmc_pkg::REG_MODE
      && wrData_q[9] && !wrData_q[15] |=> mode_q.anegRestart ##1 !mode_q.anegRestart)
    else $error("restart autonegotiation is not a single pulse");
  modeWrite_a: assert property (wrStb_q && !busy_q && regAddr_q == pmc_pkg::REG_MODE
      && !wrData_q[15] |=> (mode_q & ~pmc_pkg::RESTART_MASK) ==
      ($past(wrData_q[14:6]) & ~pmc_pkg::RESTART_MASK))
    else $error("mode control write not applied");
  pageGate_a: assert property (wrStb_q && !busy_q && regAddr_q == pmc_pkg::REG_PAGE
      |=> mainPageSel == ($past(wrData_q) == pmc_pkg::PAGE_MAIN))
    else $error("main page select does not follow page register");
  resetValue_a: assert property ($fell(busy_q) |-> mode_q == pmc_pkg::MODE_RESET)
    else $error("mode register not at reset value after software reset");
  // checked at capture: the reset window may end between header and turnaround
  readRsvd_a: assert property (state_q == pmc_pkg::ST_HDR && bitCnt_q == pmc_pkg::HDR_LAST
      && mdcRise && header[4:0] == pmc_pkg::REG_MODE
      |=> rdShift_q[5:0] == pmc_pkg::MODE_RSVD && rdShift_q[15] == $past(busy_q))
    else $error("mode control readback wrong in reserved or reset bits");
  turnDrive_a: assert property (state_q == pmc_pkg::ST_TURN && bitCnt_q == 4'h0 && mdcRise
      && hit_q && isRead_q |=> mdioOe && !mdioOut ##1 mdioOe [*2])
    else $error("turnaround zero not driven on read");
  busRelease_a: assert property ($fell(mdioOe) |-> state_q == pmc_pkg::ST_IDLE)
    else $error("data pin released outside frame end");

endmodule : pmc_mode_control

// ===== dv/pmc_host.sv
`timescale 1ns/1ns
// ----------------------------------------
// management host model
// ----------------------------------------
module pmc_host #(
  parameter logic [4:0] PHY_ADDR = 5'h00,
  parameter int PRE_LEN = 32
) (
  // clock
  input wire logic clock,
  // management pins
  output logic mdc,
  output logic mdioIn,
  input wire logic mdioOut,
  input wire logic mdioOe
);
  logic hostOe = 1'b0;
  logic hostBit = 1'b0;
  initial mdc = 1'b0;
  // pulled-up line: reads one when nobody drives it
  assign mdioIn = mdioOe ? mdioOut : (hostOe ? hostBit : 1'b1);

  task automatic bit_cyc(input logic drv, input logic val, output logic smp);
    hostOe = drv;
    hostBit = val;
    repeat (4) @(negedge clock);
    smp = mdioIn;
    mdc = 1'b1;
    repeat (4) @(negedge clock);
    mdc = 1'b0;
  endtask : bit_cyc

  task automatic xfer(input logic wr, input logic [4:0] addr, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    hdr = {2'b01, wr ? pmc_pkg::OP_WRITE : pmc_pkg::OP_READ, PHY_ADDR, addr};
    for (int i = 0; i < PRE_LEN; i++) begin
      bit_cyc(1'b1, 1'b1, s);
    end
    for (int i = 13; i >= 0; i--) begin
      bit_cyc(1'b1, hdr[i], s);
    end
    bit_cyc(wr, 1'b1, s);
    bit_cyc(wr, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(wr, wd[i], s);
      rd[i] = s;
    end
    hostOe = 1'b0;
    // parked gap so a write has landed before anyone looks
    repeat (8) @(negedge clock);
  endtask : xfer
endmodule : pmc_host

// ===== dv/testbench.sv
`timescale 1ns/1ns
module testbench;
  // ----------------------------------------
  // design, host and bookkeeping
  // ----------------------------------------
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic mdc;
  logic mdioIn;
  logic mdioOut;
  logic mdioOe;
  pmc_pkg::pmc_mode_type modeCtrl;
  logic swResetBusy;
  logic mainPageSel;
  int fail_count = 0;
  int n_compared = 0;
  int restartCount = 0;
  int expRestart = 0;
  integer seed = 57777;
  logic [15:0] rd;
  logic [15:0] wd;

  always #2 clock = ~clock;

  pmc_mode_control u_pmc_mode_control (.clock(clock), .sys_rst(sys_rst), .mdc(mdc),
    .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe), .modeCtrl(modeCtrl),
    .swResetBusy(swResetBusy), .mainPageSel(mainPageSel));
  pmc_host u_pmc_host (.clock(clock), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
    .mdioOe(mdioOe));

  // every clock of the pulse is counted, so a long pulse shows up
  always @(posedge clock) begin
    if (modeCtrl.anegRestart === 1'b1) begin
      restartCount <= restartCount + 1;
    end
  end

  function automatic logic [15:0] exp_read(input logic [15:0] w);
    return {1'b0, w[14:10], 1'b0, w[8:6], 6'h00};
  endfunction : exp_read

  function automatic pmc_pkg::pmc_mode_type exp_mode(input logic [15:0] w);
    return {w[14:10], 1'b0, w[8:6]};
  endfunction : exp_mode

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_mode(input pmc_pkg::pmc_mode_type got, input pmc_pkg::pmc_mode_type exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: mode %h expected %h", $time, got, exp);
    end
  endtask : chk_mode

  task automatic print_verdict();
    $display("compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic wr_mode(input logic [15:0] w);
    u_pmc_host.xfer(1'b1, pmc_pkg::REG_MODE, w, rd);
    expRestart += w[9];
    chk_mode(modeCtrl, exp_mode(w));
    u_pmc_host.xfer(1'b0, pmc_pkg::REG_MODE, 16'h0000, rd);
    chk_word(rd, exp_read(w));
    chk_word(16'(restartCount), 16'(expRestart));
  endtask : wr_mode

  initial begin
    logic done;
    done = 1'b0;
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    chk_mode(modeCtrl, exp_mode(16'h3000));
    u_pmc_host.xfer(1'b0, pmc_pkg::REG_MODE, 16'h0000, rd);
    chk_word(rd, 16'h3000);
    wr_mode(16'h4000);
    wr_mode(16'h0800);
    wr_mode(16'h0400);
    wr_mode(16'h0300);
    wr_mode(16'h0280);
    wr_mode(16'h003f);
    for (int c = 0; c < 4; c++) begin
      wr_mode({2'b00, c[0], 1'b1, 5'h00, c[1], 6'h00});
    end
    for (int n = 0; n < 6; n++) begin
      wd = 16'($random(seed));
      wd[15] = 1'b0;
      wr_mode(wd);
    end
    u_pmc_host.xfer(1'b1, pmc_pkg::REG_PAGE, 16'h0002, rd);
    chk_word({15'h0000, mainPageSel}, 16'h0000);
    u_pmc_host.xfer(1'b0, pmc_pkg::REG_PAGE, 16'h0000, rd);
    chk_word(rd, 16'h0002);
    u_pmc_host.xfer(1'b1, pmc_pkg::REG_PAGE, 16'h0000, rd);
    chk_word({15'h0000, mainPageSel}, 16'h0001);
    u_pmc_host.xfer(1'b1, pmc_pkg::REG_PAGE, 16'h0001, rd);
    chk_word({15'h0000, mainPageSel}, 16'h0000);
    u_pmc_host.xfer(1'b1, pmc_pkg::REG_MODE, 16'hc5c0, rd);
    chk_word({15'h0000, swResetBusy}, 16'h0001);
    repeat (260) @(negedge clock);
    for (int p = 0; p < 4 && !done; p++) begin
      u_pmc_host.xfer(1'b0, pmc_pkg::REG_MODE, 16'h0000, rd);
      done = (rd[15] === 1'b0);
    end
    if (!done) begin
      fail_count++;
      $display("CHECK FAILED at %0t: reset bit never cleared", $time);
    end else begin
      chk_word(rd, 16'h3000);
      chk_mode(modeCtrl, exp_mode(16'h3000));
      chk_word({15'h0000, mainPageSel}, 16'h0001);
      // hardware reset in mid-run, between frames with mdc parked low
      u_pmc_host.xfer(1'b1, pmc_pkg::REG_PAGE, 16'h0003, rd);
      u_pmc_host.xfer(1'b1, pmc_pkg::REG_MODE, 16'h4100, rd);
      chk_mode(modeCtrl, exp_mode(16'h4100));
      sys_rst = 1'b1;
      repeat (3) @(negedge clock);
      sys_rst = 1'b0;
      repeat (4) @(negedge clock);
      chk_mode(modeCtrl, exp_mode(16'h3000));
      chk_word({15'h0000, mainPageSel}, 16'h0001);
      u_pmc_host.xfer(1'b0, pmc_pkg::REG_MODE, 16'h0000, rd);
      chk_word(rd, 16'h3000);
    end
    print_verdict();
  end
endmodule : testbench
